// ### iabd_defines.vh
// How it works
// - Own-address bits 15..8 read zero; writes to them are dropped
// - Own-address bit 0 is read-only and reads zero
// - Own-address bits 7..1 hold the slave address compared on the bus
// - Seven-bit field is the full 7-bit address or low bits of 10-bit
// - Factor code: 00 gives 1, 01 gives 2, 10 gives 4, 11 reserved
// - Six-bit rate index selects SCL divider and three hold values
// - Bit rate is bus clock over factor times SCL divider
// - SDA changes factor times SDA hold clocks after SCL falls
// - START: SCL falls factor times start hold clocks after SDA falls
// - STOP: SDA rises factor times stop hold clocks after SCL rises
`ifndef IABD_DEFINES_VH
`define IABD_DEFINES_VH
`define IABD_OFS_ADDR 32'h0000_0000
`define IABD_OFS_DIV 32'h0000_0004
`define IABD_OFS_STAT 32'h0000_0008
`define IABD_ADDR_RST 7'h00
`define IABD_DIV_RST 8'h00
`define IABD_ADDR_MSB 7
`define IABD_ADDR_LSB 1
`define IABD_CODE_MSB 7
`define IABD_CODE_LSB 6
`define IABD_IDX_MSB 5
`define IABD_IDX_LSB 0
`define IABD_CODE_X1 2'h0
`define IABD_CODE_X2 2'h1
`define IABD_CODE_X4 2'h2
`endif

// ### iabd_top.v
// The APB interface to the registers was decided locally.
`include "iabd_defines.vh"
module iabd_top #(
   parameter CW = 16
)(
   input wire CORE_CLK,
   input wire RESET,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [31:0] PADDR,
   input wire [31:0] PWDATA,
   output wire PREADY,
   output wire PSLVERR,
   output reg [31:0] PRDATA,
   input wire START_REQ,
   input wire STOP_REQ,
   input wire SDA_NEXT,
   input wire SDA_CHANGE_REQ,
   output reg SCL_TICK,
   output reg SCL_LEVEL,
   output reg SDA_STEP,
   output reg START_SCL_FALL,
   output reg STOP_SDA_RISE,
   output wire [6:0] OWN_ADDR7,
   output wire [2:0] RATE_FACTOR,
   output wire [CW-1:0] SCL_DIVIDER
);
   reg [6:0] own_addr_q;
   reg [7:0] div_q;
   wire [1:0] rate_factor_code;
   wire [5:0] clock_rate_index;
   reg [2:0] mul;
   reg [CW-1:0] scl_div, sda_hold, start_hold, stop_hold;
   reg [CW-1:0] half_q, half_d;
   reg [CW+2:0] hcnt_q, scnt_q, pcnt_q, tcnt_q;
   wire [CW+2:0] period;
   // Sized unit step so counter arithmetic keeps its own width
   wire [CW+2:0] one_w = {{(CW+2){1'b0}}, 1'b1};
   wire wr, rd;
   assign wr = PSEL & PENABLE & PWRITE;
   assign rd = PSEL & ~PWRITE;
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;
   assign rate_factor_code = div_q[`IABD_CODE_MSB:`IABD_CODE_LSB];
   assign clock_rate_index = div_q[`IABD_IDX_MSB:`IABD_IDX_LSB];
   assign OWN_ADDR7 = own_addr_q;
   assign RATE_FACTOR = mul;
   assign SCL_DIVIDER = scl_div;
   // Product of factor and divider: one SCL period in clocks
   assign period = {3'h0, scl_div} * {{CW{1'b0}}, mul};
   // Reserved factor code falls back to 1 so counts stay finite
   always @*
   begin
      case (rate_factor_code)
         `IABD_CODE_X1: mul = 3'h1;
         `IABD_CODE_X2: mul = 3'h2;
         `IABD_CODE_X4: mul = 3'h4;
         default: mul = 3'h1;
      endcase
   end
   // Constant table; entries follow the usual divider progression
   always @*
   begin
      sda_hold = {{(CW-6){1'b0}}, clock_rate_index}
         + {{(CW-1){1'b0}}, 1'b1};
      case (clock_rate_index[5:3])
         3'h0: scl_div = 16'd20 + {clock_rate_index[2:0], 1'b0};
         3'h1: scl_div = 16'd48 + {clock_rate_index[2:0], 3'h0};
         3'h2: scl_div = 16'd80 + {clock_rate_index[2:0], 4'h0};
         3'h3: scl_div = 16'd160 + {clock_rate_index[2:0], 5'h0};
         3'h4: scl_div = 16'd320 + {clock_rate_index[2:0], 6'h0};
         3'h5: scl_div = 16'd640 + {clock_rate_index[2:0], 7'h0};
         3'h6: scl_div = 16'd1280 + {clock_rate_index[2:0], 8'h0};
         default: scl_div = 16'd2560 + {clock_rate_index[2:0], 9'h0};
      endcase
      start_hold = (scl_div >> 1) - {{(CW-2){1'b0}}, 2'h3};
      stop_hold = (scl_div >> 1) + {{(CW-1){1'b0}}, 1'b1};
      half_d = scl_div >> 1;
   end
   always @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         own_addr_q <= `IABD_ADDR_RST;
         div_q <= `IABD_DIV_RST;
      end
      else if (wr)
      begin
         if (PADDR == `IABD_OFS_ADDR)
            own_addr_q <= PWDATA[`IABD_ADDR_MSB:`IABD_ADDR_LSB];
         if (PADDR == `IABD_OFS_DIV)
            div_q <= PWDATA[7:0];
      end
   end
   always @*
   begin
      PRDATA = 32'h0;
      if (rd && PADDR == `IABD_OFS_ADDR)
         PRDATA = {24'h0, own_addr_q, 1'b0};
      else if (rd && PADDR == `IABD_OFS_DIV)
         PRDATA = {24'h0, div_q};
      else if (rd && PADDR == `IABD_OFS_STAT)
         PRDATA = {31'h0, SCL_LEVEL};
   end
   // Timers: SCL toggles every half period; holds counted in bus clocks
   always @(posedge CORE_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         hcnt_q <= 0; scnt_q <= 0; pcnt_q <= 0; tcnt_q <= 0;
         half_q <= 0;
         SCL_TICK <= 1'b0; SCL_LEVEL <= 1'b1; SDA_STEP <= 1'b0;
         START_SCL_FALL <= 1'b0; STOP_SDA_RISE <= 1'b0;
      end
      else
      begin
         half_q <= half_d;
         SCL_TICK <= 1'b0;
         SDA_STEP <= 1'b0;
         START_SCL_FALL <= 1'b0;
         STOP_SDA_RISE <= 1'b0;
         if (hcnt_q + one_w >= (period >> 1))
         begin
            hcnt_q <= 0;
            SCL_TICK <= 1'b1;
            SCL_LEVEL <= ~SCL_LEVEL;
            if (SCL_LEVEL && SDA_CHANGE_REQ)
               scnt_q <= {3'h0, sda_hold} * mul;
         end
         else
            hcnt_q <= hcnt_q + one_w;
         if (scnt_q != 0)
         begin
            scnt_q <= scnt_q - one_w;
            if (scnt_q == 1)
               SDA_STEP <= 1'b1;
         end
         if (START_REQ && pcnt_q == 0)
            pcnt_q <= {3'h0, start_hold} * mul;
         else if (pcnt_q != 0)
         begin
            pcnt_q <= pcnt_q - one_w;
            if (pcnt_q == 1)
               START_SCL_FALL <= 1'b1;
         end
         if (STOP_REQ && tcnt_q == 0)
            tcnt_q <= {3'h0, stop_hold} * mul;
         else if (tcnt_q != 0)
         begin
            tcnt_q <= tcnt_q - one_w;
            if (tcnt_q == 1)
               STOP_SDA_RISE <= 1'b1;
         end
      end
   end
endmodule // iabd_top

// ### iabd_chk_asserts.sv
`include "iabd_defines.vh"
module iabd_chk (
   input logic CORE_CLK,
   input logic RESET,
   input logic PSEL,
   input logic PENABLE,
   input logic PWRITE,
   input logic [31:0] PADDR,
   input logic [31:0] PWDATA,
   input logic [31:0] PRDATA,
   input logic [6:0] OWN_ADDR7,
   input logic [2:0] RATE_FACTOR
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   wire acc = PSEL && PENABLE;
   wire ra = acc && !PWRITE && PADDR == `IABD_OFS_ADDR;
   wire rv = acc && !PWRITE && PADDR == `IABD_OFS_DIV;
   wire wv = acc && PWRITE && PADDR == `IABD_OFS_DIV;
   sequence s_wa;
      PSEL && !PENABLE ##1 acc && PWRITE && PADDR == `IABD_OFS_ADDR;
   endsequence
   a_addr_hi: assert property (ra |-> PRDATA[31:8] == 0)
      else $error("own address high bits not zero");
   a_addr_lsb: assert property (ra |-> !PRDATA[0])
      else $error("own address bit 0 not zero");
   a_addr_keep: assert property (s_wa |=> OWN_ADDR7 == $past(PWDATA[7:1]))
      else $error("own address not stored");
   a_addr_use: assert property (ra |-> PRDATA[7:1] == OWN_ADDR7)
      else $error("own address output differs");
   a_fac_one: assert property (wv && PWDATA[7:6] == 0 |=> RATE_FACTOR == 1)
      else $error("factor not 1");
   a_fac_two: assert property (wv && PWDATA[7:6] == 1 |=> RATE_FACTOR == 2)
      else $error("factor not 2");
   a_fac_four: assert property (wv && PWDATA[7:6] == 2 |=> RATE_FACTOR == 4)
      else $error("factor not 4");
   a_div_hi: assert property (rv |-> PRDATA[31:8] == 0)
      else $error("divider high bits not zero");
endmodule // iabd_chk
bind iabd_top iabd_chk u_chk (.*);

// ### iabd_peer.sv
module iabd_peer (
   input logic clk,
   input logic tick,
   output logic start,
   output logic stop,
   output logic chg,
   output logic nxt
);
   timeunit 1ns;
   timeprecision 1ns;
   // Follows SCL ticks so the hold timers keep being armed
   initial {start, stop, chg, nxt} = 4'h0;
   always @(posedge clk)
   begin
      // Held high so every SCL fall arms the SDA hold timer
      chg <= 1'b1;
      nxt <= nxt ^ tick;
      start <= tick & nxt;
      stop <= tick & ~nxt;
   end
endmodule // iabd_peer

// ### iabd_top_tb.sv
`include "iabd_defines.vh"
module iabd_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, sel = 0, en = 0, wr = 0, rdy, st, sp, chg, nxt, tk;
   logic [31:0] a = 0, wd = 0, rd, rq;
   logic [6:0] own;
   logic [2:0] fac;
   logic [15:0] dv;
   logic lvl, ss, sf, sr;
   int err_count = 0, n_checks = 0;
   int n = 0, n_sf = 0, n_sr = 0;
   initial forever #25 clk = ~clk;
   iabd_top dut (.CORE_CLK(clk), .RESET(rst), .PSEL(sel), .PENABLE(en),
      .PWRITE(wr), .PADDR(a), .PWDATA(wd), .PREADY(rdy), .PSLVERR(),
      .PRDATA(rd), .START_REQ(st), .STOP_REQ(sp), .SDA_NEXT(nxt),
      .SDA_CHANGE_REQ(chg), .SCL_TICK(tk), .SCL_LEVEL(lvl), .SDA_STEP(ss),
      .START_SCL_FALL(sf), .STOP_SDA_RISE(sr), .OWN_ADDR7(own),
      .RATE_FACTOR(fac), .SCL_DIVIDER(dv));
   always @(posedge clk)
   begin
      if (sf === 1'b1)
         n_sf++;
      if (sr === 1'b1)
         n_sr++;
   end
   iabd_peer u_peer (.clk(clk), .tick(tk), .start(st), .stop(sp),
      .chg(chg), .nxt(nxt));
   task automatic xfer(input logic w, input logic [31:0] ad, d);
      @(posedge clk);
      sel <= 1;
      wr <= w;
      a <= ad;
      wd <= d;
      @(posedge clk);
      en <= 1;
      do @(posedge clk); while (rdy !== 1'b1);
      rq = rd;
      sel <= 0;
      en <= 0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, s);
      n_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      #300000;
      err_count++;
      conclude;
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 0;
      xfer(0, `IABD_OFS_ADDR, 0);
      chk("addr_rst", 0, rq);
      xfer(1, `IABD_OFS_ADDR, 32'hffff_ffff);
      xfer(0, `IABD_OFS_ADDR, 0);
      chk("addr", 32'h0000_00fe, rq);
      chk("own", 32'h0000_007f, {25'h0, own});
      xfer(1, `IABD_OFS_ADDR, 32'h0000_0055);
      xfer(0, `IABD_OFS_ADDR, 0);
      chk("addr2", 32'h0000_0054, rq);
      $display("address test done");
      for (int i = 0; i < 3; i++)
      begin
         xfer(1, `IABD_OFS_DIV, 32'h0000_ff2a | (i << 6));
         xfer(0, `IABD_OFS_DIV, 0);
         chk("div", 32'h0000_002a | (i << 6), rq);
         chk("factor", 1 << i, {29'h0, fac});
      end
      // Unmapped space must read zero and leave both registers alone
      xfer(1, 32'h0000_0010, 32'hffff_ffff);
      xfer(0, 32'h0000_0010, 0);
      chk("unmapped", 0, rq);
      xfer(0, `IABD_OFS_ADDR, 0);
      chk("addr_kept", 32'h0000_0054, rq);
      xfer(0, `IABD_OFS_DIV, 0);
      chk("div_kept", 32'h0000_00aa, rq);
      repeat (300) @(posedge clk);
      $display("divider test done");
      // Factor two, first index: SCL half period is factor*divider/2
      xfer(1, `IABD_OFS_DIV, 32'h0000_0040);
      n_sf = 0;
      n_sr = 0;
      repeat (50) @(posedge clk);
      @(posedge clk iff tk === 1'b1);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (tk !== 1'b1 && n < 5000);
      chk("scl_half", ({29'h0, fac} * {16'h0, dv}) >> 1, n);
      @(posedge clk iff (tk === 1'b1 && lvl === 1'b0));
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ss !== 1'b1 && n < 5000);
      chk("sda_hold", 1, (n > 0 && n < ((fac * dv) >> 1)));
      repeat (200) @(posedge clk);
      chk("start_hold", 1, n_sf > 0);
      chk("stop_hold", 1, n_sr > 0);
      $display("timing test done");
      conclude;
   end
endmodule // iabd_top_tb
